// File: src/ep_buf_consts.vh
/*
  constants for the endpoint buffer access block: register offsets,
  field positions, reset values and sizes.
  assumes inclusion by bare name from design files.
*/
`ifndef EP_BUF_CONSTS_VH
`define EP_BUF_CONSTS_VH

`define OFS_FIFO_WINDOW     6'h20
`define OFS_BUFFER_CONTROL  6'h28
`define OFS_ENDPOINT_INDEX  6'h2C
`define OFS_BUFFER_LENGTH   6'h1C
`define OFS_MAX_PACKET      6'h04
`define OFS_ENDPOINT_TYPE   6'h08
`define OFS_ENDPOINT_STATUS 6'h30

`define IDX_SETUP_BIT       5
`define IDX_NUM_HI          4
`define IDX_NUM_LO          1
`define IDX_DIR_BIT         0

`define CTL_STALL_BIT       0
`define CTL_STATUS_BIT      1
`define CTL_COMMIT_BIT      3
`define CTL_FLUSH_BIT       4

`define TYPE_ENABLE_BIT     3
`define TYPE_ISO            2'h1

`define FIFO_WORD_RESET     16'h0000
`define CTL_RESET           8'h00
`define FIFO_DEPTH_WORDS    16
`define NUM_ENDPOINTS       16

`endif

// File: src/ep_byte_fifo.v
/*
  synchronous fifo with valid/ready on both sides and flush.
  assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ep_byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             i_clk_sys,
  input  wire             i_resetn,
  input  wire             i_flush,
  // fill side
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  // drain side
  output wire             o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready,
  // level
  output wire [AW:0]      o_level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  assign o_in_ready  = (count_ff != DEPTH[AW:0]);
  assign o_out_valid = (count_ff != {(AW+1){1'b0}});
  assign o_out_data  = mem[rd_ptr_ff];
  assign o_level     = count_ff;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_clk_sys) begin
    if (push)
      mem[wr_ptr_ff] <= i_in_data;
  end

  always @(posedge i_clk_sys) begin
    if (!i_resetn || i_flush) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop)
        count_ff <= count_ff + 1'b1;
      else if (pop && !push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: src/ep_buffer_access.v
/*
  endpoint buffer management and fifo access of a usb peripheral.
  mcu reaches registers through a simple parallel bus (address, cs,
  rd/wr strobes, 16-bit data, bus-width select). usb side sees one
  byte stream each way for the selected endpoint plus token strobes.
  assumes bus strobes are synchronous one-cycle pulses on i_clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ep_buf_consts.vh"
module ep_buffer_access #(
  parameter DEPTH = `FIFO_DEPTH_WORDS,
  parameter AW    = 4
) (
  // clock and reset
  input  wire        i_clk_sys,
  input  wire        i_resetn,
  input  wire        i_usb_bus_reset,
  // mcu register bus
  input  wire [5:0]  i_addr,
  input  wire        i_cs,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire        i_bus16,
  input  wire [15:0] i_wdata,
  output reg  [15:0] o_rdata,
  // usb side, transmit stream
  output reg  [7:0]  o_tx_data,
  output reg         o_tx_valid,
  input  wire        i_tx_ready,
  // usb side, receive stream
  input  wire [7:0]  i_rx_data,
  input  wire        i_rx_valid,
  output reg         o_rx_ready,
  // usb token events
  input  wire        i_setup_token,
  input  wire        i_status_done,
  input  wire        i_rx_packet_end,
  input  wire        i_tx_packet_sent,
  // endpoint answers
  output reg         o_stall,
  output reg         o_status_ack,
  output reg         o_tx_committed,
  output reg         o_rx_full
);
  reg  [5:0]  index_ff;
  reg  [7:0]  ctl_ff;
  reg  [`NUM_ENDPOINTS-1:0] stall_ff;
  reg  [3:0]  ep_type_ff;
  reg  [10:0] max_pkt_ff;
  reg  [15:0] buf_len_ff;
  reg  [15:0] fifo_word_ff;
  reg  [15:0] tx_cnt_ff;
  reg  [15:0] rx_cnt_ff;
  reg         commit_ff;
  reg         rx_pkt_ff;
  reg         hi_pend_ff;
  reg  [7:0]  hi_byte_ff;
  reg  [15:0] nxt_rdata;

  wire        rst_all;
  wire        wr_cycle;
  wire        rd_cycle;
  wire [3:0]  ep_num;
  wire        dir_in;
  wire        ep_enabled;
  wire        ep_iso;
  wire        flush_cmd;
  wire        commit_cmd;
  wire        tx_in_ready;
  wire        tx_push;
  wire [7:0]  tx_push_data;
  wire        rx_out_valid;
  wire [7:0]  rx_out_data;
  wire        rx_pop;
  wire        rx_flush;
  wire [AW:0] tx_level;
  wire [AW:0] rx_level;
  wire [15:0] tx_cnt_next;
  wire        rx_drained;
  wire        tx_full_pkt;
  wire [4:0]  stall_idx;
  wire        rx_done;
  wire        tx_pop;
  localparam [AW:0] RX_HEADROOM = DEPTH - 1;

  assign rst_all  = !i_resetn || i_usb_bus_reset;
  assign wr_cycle = i_cs && i_wr;
  assign rd_cycle = i_cs && i_rd;
  assign ep_num   = index_ff[`IDX_NUM_HI:`IDX_NUM_LO];
  assign dir_in   = index_ff[`IDX_DIR_BIT];
  assign ep_enabled = ep_type_ff[`TYPE_ENABLE_BIT] || (ep_num == 4'h0);
  assign ep_iso   = (ep_type_ff[1:0] == `TYPE_ISO);
  assign stall_idx = {1'b0, ep_num};

  // buffer control writes act only on enabled endpoints
  assign flush_cmd  = wr_cycle && (i_addr == `OFS_BUFFER_CONTROL) &&
                      ep_enabled && i_wdata[`CTL_FLUSH_BIT];
  assign commit_cmd = wr_cycle && (i_addr == `OFS_BUFFER_CONTROL) &&
                      ep_enabled && i_wdata[`CTL_COMMIT_BIT] && dir_in;

  // data port write: low byte first, high byte queued on 16-bit bus
  assign tx_push      = (wr_cycle && (i_addr == `OFS_FIFO_WINDOW) &&
                        dir_in && !index_ff[`IDX_SETUP_BIT]) || hi_pend_ff;
  assign tx_push_data = hi_pend_ff ? hi_byte_ff : i_wdata[7:0];
  assign tx_cnt_next  = (i_tx_packet_sent ? 16'h0000 : tx_cnt_ff) + 16'h0001;
  assign tx_full_pkt  = (tx_cnt_next == {5'h00, max_pkt_ff}) ||
                        (tx_cnt_next == buf_len_ff);
  assign rx_pop       = rd_cycle && (i_addr == `OFS_FIFO_WINDOW) && !dir_in &&
                        rx_out_valid;
  assign rx_drained   = rx_pkt_ff && (rx_cnt_ff != 16'h0000) &&
                        (rx_cnt_ff <= (i_bus16 ? 16'h0002 : 16'h0001));
  assign rx_done      = rx_pop && (rx_drained ||
                        (rx_pkt_ff && (rx_cnt_ff == buf_len_ff)));
  assign rx_flush     = rst_all || flush_cmd || rx_done;
  assign tx_pop       = o_tx_valid && i_tx_ready;

  ep_byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_tx_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_resetn    (i_resetn),
    .i_flush     (i_usb_bus_reset),
    .i_in_valid  (tx_push),
    .i_in_data   (tx_push_data),
    .o_in_ready  (tx_in_ready),
    .o_out_valid (),
    .o_out_data  (),
    .i_out_ready (tx_pop),
    .o_level     (tx_level)
  );

  // usb drains the tx fifo only once committed
  reg  [7:0]  tx_mem [0:DEPTH-1];
  reg  [AW-1:0] tx_wp_ff;
  reg  [AW-1:0] tx_rp_ff;
  always @(posedge i_clk_sys) begin
    if (tx_push && tx_in_ready)
      tx_mem[tx_wp_ff] <= tx_push_data;
  end

  ep_byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_rx_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_resetn    (i_resetn),
    .i_flush     (rx_flush),
    .i_in_valid  (i_rx_valid && o_rx_ready),
    .i_in_data   (i_rx_data),
    .o_in_ready  (),
    .o_out_valid (rx_out_valid),
    .o_out_data  (rx_out_data),
    .i_out_ready (rx_pop),
    .o_level     (rx_level)
  );

  // register file and control
  always @(posedge i_clk_sys) begin
    if (rst_all) begin
      ctl_ff       <= `CTL_RESET;
      fifo_word_ff <= `FIFO_WORD_RESET;
      stall_ff     <= {`NUM_ENDPOINTS{1'b0}};
      buf_len_ff   <= 16'h0000;
      ep_type_ff   <= 4'h0;
      tx_cnt_ff    <= 16'h0000;
      rx_cnt_ff    <= 16'h0000;
      commit_ff    <= 1'b0;
      rx_pkt_ff    <= 1'b0;
      hi_pend_ff   <= 1'b0;
      hi_byte_ff   <= 8'h00;
      tx_wp_ff     <= {AW{1'b0}};
      tx_rp_ff     <= {AW{1'b0}};
    end else begin
      hi_pend_ff <= 1'b0;
      if (wr_cycle) begin
        case (i_addr)
          `OFS_BUFFER_CONTROL: begin
            if (ep_enabled) begin
              ctl_ff[`CTL_STATUS_BIT] <= i_wdata[`CTL_STATUS_BIT];
              if (!ep_iso)
                stall_ff[stall_idx[3:0]] <=
                  i_wdata[`CTL_STALL_BIT];
            end
          end
          `OFS_ENDPOINT_TYPE:  ep_type_ff <= i_wdata[3:0];
          `OFS_BUFFER_LENGTH:  buf_len_ff <= i_wdata;
          `OFS_FIFO_WINDOW:    fifo_word_ff <= i_wdata;
          default: begin
          end
        endcase
      end
      // status ack clears on completion or setup, set loses
      if (i_setup_token || i_status_done)
        ctl_ff[`CTL_STATUS_BIT] <= 1'b0;
      // packet sent first, so a same-cycle fill or commit wins
      if (i_tx_packet_sent) begin
        commit_ff <= 1'b0;
        tx_cnt_ff <= 16'h0000;
      end
      // transmit side fill and commit
      if (tx_push && tx_in_ready) begin
        tx_wp_ff  <= tx_wp_ff + 1'b1;
        tx_cnt_ff <= tx_cnt_next;
        if (tx_full_pkt)
          commit_ff <= 1'b1;
        if (!hi_pend_ff && i_bus16) begin
          hi_pend_ff <= 1'b1;
          hi_byte_ff <= i_wdata[15:8];
        end
      end
      if (commit_cmd)
        commit_ff <= 1'b1;
      if (tx_pop)
        tx_rp_ff <= tx_rp_ff + 1'b1;
      // receive side packet accounting
      if (i_rx_packet_end && !rx_pkt_ff) begin
        rx_pkt_ff <= 1'b1;
        rx_cnt_ff <= {{(15-AW){1'b0}}, rx_level};
      end
      if (rx_pop) begin
        fifo_word_ff <= {8'h00, rx_out_data};
        if (rx_done)
          rx_cnt_ff <= 16'h0000;
        else
          rx_cnt_ff <= rx_cnt_ff -
                       (i_bus16 ? 16'h0002 : 16'h0001);
      end
      if (flush_cmd || rx_done) begin
        rx_pkt_ff <= 1'b0;
        rx_cnt_ff <= 16'h0000;
      end
    end
  end

  // max packet register, kept across bus reset
  always @(posedge i_clk_sys) begin
    if (!i_resetn)
      max_pkt_ff <= 11'h000;
    else if (wr_cycle && (i_addr == `OFS_MAX_PACKET))
      max_pkt_ff <= i_wdata[10:0];
  end

  // index register, unchanged by bus reset
  always @(posedge i_clk_sys) begin
    if (!i_resetn)
      index_ff <= 6'h00;
    else if (wr_cycle && (i_addr == `OFS_ENDPOINT_INDEX))
      index_ff <= i_wdata[5:0];
  end

  // read mux; reserved bits read zero
  always @* begin
    nxt_rdata = 16'h0000;
    case (i_addr)
      `OFS_ENDPOINT_INDEX:  nxt_rdata = {10'h000, index_ff};
      `OFS_BUFFER_CONTROL:  nxt_rdata = {14'h0000, ctl_ff[`CTL_STATUS_BIT],
                                         stall_ff[stall_idx[3:0]]};
      `OFS_FIFO_WINDOW:     nxt_rdata = dir_in ? fifo_word_ff :
                                        {8'h00, rx_out_data};
      `OFS_BUFFER_LENGTH:   nxt_rdata = dir_in ? tx_cnt_ff : rx_cnt_ff;
      `OFS_MAX_PACKET:      nxt_rdata = {5'h00, max_pkt_ff};
      `OFS_ENDPOINT_TYPE:   nxt_rdata = {12'h000, ep_type_ff};
      `OFS_ENDPOINT_STATUS: nxt_rdata = {10'h000, rx_pkt_ff, commit_ff,
                                         1'b0, rx_level[AW:AW-2]};
      default:              nxt_rdata = 16'h0000;
    endcase
  end

  // registered outputs
  always @(posedge i_clk_sys) begin
    if (rst_all) begin
      o_rdata        <= 16'h0000;
      o_tx_data      <= 8'h00;
      o_tx_valid     <= 1'b0;
      o_rx_ready     <= 1'b0;
      o_stall        <= 1'b0;
      o_status_ack   <= 1'b0;
      o_tx_committed <= 1'b0;
      o_rx_full      <= 1'b0;
    end else begin
      o_rdata        <= nxt_rdata;
      o_tx_valid     <= commit_ff && (tx_rp_ff != tx_wp_ff) && !tx_pop;
      o_tx_data      <= tx_mem[tx_rp_ff];
      o_rx_ready     <= !rx_pkt_ff && !i_rx_packet_end &&
                        (rx_level < RX_HEADROOM);
      o_stall        <= stall_ff[stall_idx[3:0]] && !ep_iso;
      o_status_ack   <= ctl_ff[`CTL_STATUS_BIT] &&
                        !i_setup_token && !i_status_done;
      o_tx_committed <= commit_ff;
      o_rx_full      <= rx_pkt_ff;
    end
  end
endmodule
`default_nettype wire

// File: dv/ep_buf_chk.sv
/* port checker for ep_buffer_access.
   assumes bind onto the design, one clock. */
`timescale 1ns/1ps
`default_nettype none
module ep_buf_chk (
  // clock, reset and register bus
  input wire logic        i_clk_sys, i_resetn, i_usb_bus_reset,
  input wire logic        i_cs, i_wr,
  input wire logic [5:0]  i_addr,
  input wire logic [15:0] i_wdata,
  // usb side
  input wire logic        o_tx_valid, i_setup_token, i_status_done,
  input wire logic        i_tx_packet_sent,
  input wire logic        o_stall, o_status_ack, o_tx_committed, o_rx_full
);
  logic [5:0] idx_ff;
  logic [3:0] typ_ff;
  wire        ok = typ_ff[3] || idx_ff[4:1] == 4'h0;
  always @(posedge i_clk_sys) begin
    if (!i_resetn)
      idx_ff <= 6'h00;
    else if (i_cs && i_wr && i_addr == 6'h2C)
      idx_ff <= i_wdata[5:0];
    if (!i_resetn || i_usb_bus_reset)
      typ_ff <= 4'h0;
    else if (i_cs && i_wr && i_addr == 6'h08)
      typ_ff <= i_wdata[3:0];
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  sequence ctl_s;
    i_cs && i_wr && i_addr == 6'h28 && ok && !i_usb_bus_reset;
  endsequence
  sequence ep0_s;
    ctl_s ##0 (idx_ff[4:1] == 4'h0 && !i_setup_token && !i_status_done);
  endsequence
  bus_reset_a: assert property (
    i_usb_bus_reset |=> !(o_stall || o_status_ack || o_tx_committed))
    else $error("bus reset left a bit set");
  stall_set_a: assert property (
    ctl_s ##0 (i_wdata[0] && typ_ff[1:0] != 2'h1) ##1 !i_usb_bus_reset
      |=> o_stall)
    else $error("stall missed");
  iso_stall_a: assert property (
    ctl_s ##0 (typ_ff[1:0] == 2'h1 && !o_stall) |=> !o_stall)
    else $error("stall on iso");
  status_set_a: assert property (
    ep0_s ##1 !(i_setup_token || i_status_done || i_usb_bus_reset ||
      (i_cs && i_wr)) |=> o_status_ack == $past(i_wdata[1], 2))
    else $error("status bit missed");
  token_clear_a: assert property (
    i_setup_token || i_status_done |=> !o_status_ack)
    else $error("status bit kept");
  commit_cmd_a: assert property (
    ctl_s ##0 (i_wdata[3] && idx_ff[0] && !i_tx_packet_sent)
      ##1 !(i_tx_packet_sent || i_usb_bus_reset) |=> o_tx_committed)
    else $error("commit missed");
  flush_cmd_a: assert property (
    ctl_s ##0 i_wdata[4] |=> ##[0:2] !o_rx_full)
    else $error("flush missed");
  tx_valid_a: assert property (
    o_tx_valid |-> o_tx_committed || $past(o_tx_committed))
    else $error("tx byte uncommitted");
endmodule
bind ep_buffer_access ep_buf_chk chk (.i_clk_sys, .i_resetn,
  .i_usb_bus_reset, .i_cs, .i_wr, .i_addr, .i_wdata, .o_tx_valid,
  .i_setup_token, .i_status_done, .i_tx_packet_sent, .o_stall, .o_status_ack,
  .o_tx_committed, .o_rx_full);
`default_nettype wire

// File: dv/usb_host_model.sv
/* usb host side: drains tx bytes with random stalls, feeds rx bytes.
   assumes the bench fills pend and reads got. */
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  // clock
  input  wire logic       i_clk_sys,
  // tx stream from the device
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_valid,
  output var  logic       o_tx_ready,
  // rx stream into the device
  output var  logic [7:0] o_rx_data,
  output var  logic       o_rx_valid,
  input  wire logic       i_rx_ready
);
  logic [7:0] got[$];
  logic [7:0] pend[$];
  initial begin
    o_tx_ready = 0;
    o_rx_valid = 0;
    o_rx_data = 8'h00;
  end
  always @(posedge i_clk_sys) begin
    if (o_tx_ready && i_tx_valid)
      got.push_back(i_tx_data);
    o_tx_ready <= 1'($urandom_range(1, 0));
    if (o_rx_valid && i_rx_ready)
      void'(pend.pop_front());
    o_rx_valid <= pend.size() > 0;
    o_rx_data <= pend.size() > 0 ? pend[0] : ~o_rx_data;
  end
endmodule
`default_nettype wire

// File: dv/tb.sv
/* bench for ep_buffer_access with the usb host model.
   assumes design, checker and model compile first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rstn, brst, cs, wr, rd, w16;
  logic [3:0]  ev;
  logic [5:0]  addr;
  logic [15:0] wdata, rv, d;
  wire  [15:0] rdata;
  wire  [7:0]  txd, rxd;
  wire         txv, txr, rxv, rxr, stall, sack, cmt, full;
  int          mismatches, checks_done, i, k;
  logic [7:0]  q[$];
  ep_buffer_access uut (.i_clk_sys(clk), .i_resetn(rstn),
    .i_usb_bus_reset(brst), .i_addr(addr), .i_cs(cs), .i_wr(wr),
    .i_rd(rd), .i_bus16(w16), .i_wdata(wdata), .o_rdata(rdata),
    .o_tx_data(txd), .o_tx_valid(txv), .i_tx_ready(txr),
    .i_rx_data(rxd), .i_rx_valid(rxv), .o_rx_ready(rxr),
    .i_setup_token(ev[0]), .i_status_done(ev[1]),
    .i_rx_packet_end(ev[2]), .i_tx_packet_sent(ev[3]), .o_stall(stall),
    .o_status_ack(sack), .o_tx_committed(cmt), .o_rx_full(full));
  usb_host_model host (.i_clk_sys(clk), .i_tx_data(txd),
    .i_tx_valid(txv), .o_tx_ready(txr), .o_rx_data(rxd),
    .o_rx_valid(rxv), .i_rx_ready(rxr));
  function automatic logic exp_cmt(input int cnt, lim);
    return cnt >= lim;
  endfunction
  task automatic chk(input string s, input logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic bound(input int j);
    if (j >= 300) begin
      mismatches++;
      summarize;
    end
  endtask
  task automatic st;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic acc(input logic [5:0] a, input logic [15:0] v,
                     input logic w, r);
    @(posedge clk);
    {addr, wdata, w16, cs, wr, rd} <= {a, v, w, 1'b1, !r, r};
    @(posedge clk);
    {cs, wr, rd} <= 3'h0;
    #1 rv = rdata;
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1;
    @(posedge clk);
    ev[b] <= 0;
    st;
  endtask
  task automatic tx_case(input int nb, lim, input logic w);
    q = {};
    host.got = {};
    for (k = 0; k < nb; k += 1 + w) begin
      d = $urandom;
      q.push_back(d[7:0]);
      if (w)
        q.push_back(d[15:8]);
      acc(6'h20, d, w, 0);
      st;
      chk("cmt", cmt, exp_cmt(k + 1 + w, lim));
    end
    if (nb < lim) begin
      acc(6'h28, 16'h0008, 1, 0);
      st;
      chk("cmt cmd", cmt, 1);
      acc(6'h28, 16'h0000, 1, 1);
      chk("cmt bit", rv[3], 0);
    end
    for (i = 0; i < 300 && host.got.size() < q.size(); i++)
      @(posedge clk);
    bound(i);
    foreach (q[j])
      chk("tx byte", host.got[j], q[j]);
    pulse(3);
    chk("sent", cmt, 0);
  endtask
  task automatic rx_case(input int nb, input logic fl);
    q = {};
    repeat (nb) begin
      d = $urandom;
      q.push_back(d[7:0]);
      host.pend.push_back(d[7:0]);
    end
    for (i = 0; i < 300 && (host.pend.size() > 0 || rxv); i++)
      @(posedge clk);
    bound(i);
    pulse(2);
    chk("rx full", full, 1);
    if (fl)
      acc(6'h28, 16'h0010, 1, 0);
    else
      foreach (q[j]) begin
        acc(6'h20, 16'h0000, 0, 1);
        chk("rx byte", rv[7:0], q[j]);
      end
    st;
    chk("rx empty", full, 0);
  endtask
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    {rstn, brst, cs, wr, rd, w16, ev, addr, wdata} = 0;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(59));
    repeat (10) @(posedge clk);
    rstn <= 1;
    st;
    chk("outs", {stall, sack, cmt, full}, 0);
    acc(6'h2C, 16'h0000, 1, 0);
    for (k = 0; k < 2; k++) begin
      acc(6'h28, 16'h0002, 1, 0);
      st;
      chk("ack", sack, 1);
      pulse(k);
      chk("ack clr", sack, 0);
    end
    acc(6'h2C, 16'h0003, 1, 0);
    acc(6'h08, 16'h000A, 1, 0);
    acc(6'h04, 16'h0004, 1, 0);
    tx_case(4, 4, 1);
    tx_case(1, 4, 0);
    acc(6'h1C, 16'h0003, 1, 0);
    tx_case(3, 3, 0);
    acc(6'h28, 16'h0001, 1, 0);
    st;
    chk("stall", stall, 1);
    acc(6'h28, 16'h0001, 1, 1);
    chk("stall bit", rv[0], 1);
    acc(6'h28, 16'h0000, 1, 0);
    acc(6'h08, 16'h0002, 1, 0);
    acc(6'h08, 16'h0009, 1, 0);
    acc(6'h28, 16'h0001, 1, 0);
    st;
    chk("iso stall", stall, 0);
    acc(6'h08, 16'h000A, 1, 0);
    acc(6'h28, 16'h0001, 1, 0);
    @(posedge clk);
    brst <= 1;
    @(posedge clk);
    brst <= 0;
    st;
    chk("bus rst", {stall, cmt}, 0);
    acc(6'h08, 16'h000A, 1, 0);
    acc(6'h04, 16'h0004, 1, 0);
    acc(6'h2C, 16'h0002, 1, 0);
    rx_case($urandom_range(4, 1), 0);
    rx_case(4, 0);
    rx_case(3, 1);
    summarize;
  end
endmodule
`default_nettype wire
